// *** design/cop_watchdog.sv ***
// Watchdog unit: prescaler, 6-bit timeout counter, reset pulse and cause flags.
// Assumes the oscillator pin is far slower than the system clock and
// that mode inputs come from logic on the system clock.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// Overview of operation
// RULE_01: 6-bit counter stepped by 12-bit prescaler carry.
// RULE_02: Counter overflow issues a system reset.
// RULE_03: Rate bit picks short or long timeout.
// RULE_04: Service write clears counter and prescaler high.
// RULE_05: Service read returns reset vector low byte.
// RULE_06: Reset pin low 32 ticks, cause flag set.
// RULE_07: Prescaler cleared 4096 ticks after power-up.
// RULE_08: Internal reset clears prescaler and counter.
// RULE_09: Reset vector fetch clears the prescaler.
// RULE_10: Disable bit stops the watchdog.
// RULE_11: No processor interrupt; reset only.
// RULE_12: Monitor mode with test voltage disables.
// RULE_13: Counting continues in wait mode.
// RULE_14: Stop mode gates ticks, clears prescaler.
// RULE_15: Disabled stop instruction gives illegal-opcode reset.
// RULE_16: Break with test voltage on reset disables.
// RULE_17: Software services after reset and around stop.
// RULE_18: Software services from interrupt during wait.
// RULE_19: Service only on accepted write, exact address.
module cop_watchdog (
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      RST_N_I,
  input  wire logic                      INTERNAL_OSC_CLOCK_I,
  input  wire logic [cop_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                      AVS_READ_I,
  input  wire logic                      AVS_WRITE_I,
  input  wire logic [cop_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]                AVS_BYTEENABLE_I,
  output logic      [cop_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic                           AVS_WAITREQUEST_O,
  input  wire logic [7:0]                VECTOR_LO_I,
  input  wire logic                      INT_RST_I,
  input  wire logic                      VECTOR_FETCH_I,
  input  wire logic                      STOP_EXEC_I,
  input  wire logic                      STOP_EXIT_I,
  input  wire logic                      WAIT_MODE_I,
  input  wire logic                      MONITOR_MODE_I,
  input  wire logic                      BREAK_STATE_I,
  input  wire cop_pkg::vtst_s            VTST_I,
  output logic                           RST_PIN_O,
  output logic                           RST_PIN_OE_N_O,
  output logic                           WDOG_RESET_O,
  output logic                           ILLOP_RESET_O,
  output logic                           STOP_MODE_O,
  output logic                           CAUSE_IRQ_O
);
  import cop_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [2:0]           internal_osc_clock_sync_q;
  vtst_s                vtst_meta_q;
  vtst_s                vtst_q;
  logic                 tick;
  logic                 tick_run;
  logic [12:0]          por_cnt_q;
  logic                 por_done_q;
  logic                 por_clear;
  logic                 ack_q;
  logic                 req;
  logic                 acc_wr;
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;
  options_s             opt_q;
  logic [CAUSE_W-1:0]   cause_q;
  logic [CAUSE_W-1:0]   cause_en_q;
  logic [CAUSE_W-1:0]   cause_set;
  logic [CAUSE_W-1:0]   cause_clr;
  logic                 service;
  logic                 stop_q;
  logic                 stop_enter;
  logic                 illop_q;
  logic                 wdog_on;
  logic                 presc_clr_all;
  logic [PRESC_W-1:0]   presc;
  logic                 presc_carry;
  logic [WDOG_W-1:0]    wdog_q;
  logic [ELAPSED_W-1:0] elapsed_nx;
  logic [ELAPSED_W-1:0] timeout;
  logic                 overflow;
  logic                 fire_q;
  logic                 pulse_active;
  logic                 int_clear;

  // ------------------------------------------------------------------
  // Pin synchronisers and oscillator tick
  // ------------------------------------------------------------------
  // The oscillator is sampled, not used as a clock, so the whole unit
  // stays in one domain; its rate must stay well under half of ours.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      internal_osc_clock_sync_q <= 3'h0;
    end else begin
      internal_osc_clock_sync_q <= {internal_osc_clock_sync_q[1:0], INTERNAL_OSC_CLOCK_I};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      vtst_meta_q <= '0;
      vtst_q      <= '0;
    end else begin
      vtst_meta_q <= VTST_I;
      vtst_q      <= vtst_meta_q;
    end
  end

  assign tick     = internal_osc_clock_sync_q[1] & ~internal_osc_clock_sync_q[2];
  assign tick_run = tick & ~stop_q; // [RULE_14]

  // ------------------------------------------------------------------
  // Power-up settle count
  // ------------------------------------------------------------------
  // The settle count runs once after reset and then stands still.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      por_cnt_q  <= 13'h0000;
      por_done_q <= 1'b0;
    end else if (!por_done_q && tick) begin
      por_cnt_q  <= por_cnt_q + 13'h0001;
      por_done_q <= (por_cnt_q == 13'(POR_TICKS - 1));
    end
  end

  assign por_clear = tick & ~por_done_q & (por_cnt_q == 13'(POR_TICKS - 1)); // [RULE_07]

  // ------------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ------------------------------------------------------------------
  // A fixed single wait state lets read data come from a flip-flop
  // without a second decode path for the answer.
  assign req               = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~ack_q;
  assign acc_wr            = AVS_WRITE_I & ack_q;
  assign AVS_READDATA_O    = rdata_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Unmapped words and the write-only clear word read as zero.
  always_comb begin
    rdata_d = '0;
    unique case (AVS_ADDRESS_I)
      SERVICE_IDX: rdata_d[7:0] = VECTOR_LO_I; // [RULE_05]
      OPTIONS_IDX: rdata_d[2:0] = opt_q;
      CAUSE_IDX:   rdata_d[CAUSE_W-1:0] = cause_q;
      ENABLE_IDX:  rdata_d[CAUSE_W-1:0] = cause_en_q;
      COUNT_IDX: begin
        rdata_d[WDOG_W-1:0]  = wdog_q;
        rdata_d[CNT_WAIT_BIT] = WAIT_MODE_I;
        rdata_d[CNT_STOP_BIT] = stop_q;
        rdata_d[CNT_RUN_BIT]  = wdog_on;
      end
      default:     rdata_d = '0;
    endcase
  end

  // Read data is captured in the waiting cycle and stands at the
  // edge where waitrequest is low.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rdata_q <= '0;
    end else if (AVS_READ_I && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // Option register
  // ------------------------------------------------------------------
  // Writes to read-only or unmapped words are dropped without an error.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      opt_q <= OPTIONS_RST; // [RULE_03]
    end else if (acc_wr && AVS_ADDRESS_I == OPTIONS_IDX && AVS_BYTEENABLE_I[0]) begin
      opt_q <= AVS_WRITEDATA_I[2:0];
    end
  end

  // Any byte lane and any data value counts as a service.
  assign service = acc_wr & (AVS_ADDRESS_I == SERVICE_IDX); // [RULE_19] [RULE_04]

  // ------------------------------------------------------------------
  // Stop mode and illegal stop
  // ------------------------------------------------------------------
  // A second stop instruction while already stopped is ignored.
  assign stop_enter = STOP_EXEC_I & ~opt_q.stop_dis & ~stop_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      stop_q <= 1'b0;
    end else if (int_clear || STOP_EXIT_I) begin
      stop_q <= 1'b0;
    end else if (stop_enter) begin
      stop_q <= 1'b1; // [RULE_14]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      illop_q <= 1'b0;
    end else begin
      illop_q <= STOP_EXEC_I & opt_q.stop_dis; // [RULE_15]
    end
  end

  // ------------------------------------------------------------------
  // Enable terms
  // ------------------------------------------------------------------
  // Wait mode is deliberately absent here: the count keeps running. [RULE_13]
  always_comb begin
    wdog_on = 1'b1;
    if (opt_q.dis) begin
      wdog_on = 1'b0; // [RULE_10]
    end
    if (MONITOR_MODE_I && (vtst_q.on_irq || vtst_q.on_rst)) begin
      wdog_on = 1'b0; // [RULE_12]
    end
    if (BREAK_STATE_I && vtst_q.on_rst) begin
      wdog_on = 1'b0; // [RULE_16]
    end
  end

  // ------------------------------------------------------------------
  // Prescaler and timeout counter
  // ------------------------------------------------------------------
  // Internal reset covers an external request, our own timeout reset and the illegal-stop reset.
  assign int_clear = INT_RST_I | fire_q | illop_q; // [RULE_08]

  // A service clears only the upper stages, through clr_hi_i; every
  // other source restarts the whole prescaler.
  assign presc_clr_all = int_clear
                       | VECTOR_FETCH_I // [RULE_09]
                       | por_clear
                       | stop_enter; // [RULE_14]

  cop_prescaler #(
    .WIDTH  (PRESC_W),
    .CLR_LO (SVC_CLR_LO)
  ) u_presc (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RST_N_I),
    .tick_i    (tick_run),
    .clr_all_i (presc_clr_all),
    .clr_hi_i  (service),
    .count_o   (presc),
    .carry_o   (presc_carry)
  );

  // Holding the counter at zero while disabled gives a timeout, short by the
  // free-running prescaler's count, as soon as the watchdog is enabled again.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wdog_q <= '0;
    end else if (int_clear || service || !wdog_on) begin
      wdog_q <= '0; // [RULE_04] [RULE_08]
    end else if (presc_carry) begin
      wdog_q <= wdog_q + 1'b1; // [RULE_01]
    end
  end

  // The service clears only the upper prescaler stages, so the low
  // stages make the timeout short of a power of two.
  assign timeout    = opt_q.rate ? TIMEOUT_SHORT : TIMEOUT_LONG; // [RULE_03]
  assign elapsed_nx = {wdog_q, presc} + 1'b1;
  // A service or internal reset in the same cycle wins over the
  // overflow tick, so software that is just in time is not punished.
  assign overflow   = wdog_on
                    & tick_run
                    & ~service
                    & ~int_clear
                    & (elapsed_nx == timeout);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= overflow; // [RULE_02]
    end
  end

  // The pulse counts every rising oscillator edge, even in stop mode, so a
  // started reset always runs to its end.
  cop_pulse_stretch #(
    .TICKS (RST_PULSE_TICKS)
  ) u_stretch (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RST_N_I),
    .start_i  (fire_q),
    .tick_i   (tick),
    .active_o (pulse_active)
  );

  // ------------------------------------------------------------------
  // Reset cause flags and their event output
  // ------------------------------------------------------------------
  // This output marks recorded reset causes for a status controller;
  // it is not a processor interrupt request. [RULE_11]
  assign cause_set = {illop_q, fire_q}; // [RULE_06]
  assign cause_clr = (acc_wr && AVS_ADDRESS_I == CLEAR_IDX && AVS_BYTEENABLE_I[0])
                   ? AVS_WRITEDATA_I[CAUSE_W-1:0] : '0;

  // A set and a clear in one cycle leave the flag set, so no cause is lost.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      cause_q <= CAUSE_RST;
    end else begin
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      cause_en_q <= CAUSE_RST;
    end else if (acc_wr && AVS_ADDRESS_I == ENABLE_IDX && AVS_BYTEENABLE_I[0]) begin
      cause_en_q <= AVS_WRITEDATA_I[CAUSE_W-1:0];
    end
  end

  assign CAUSE_IRQ_O = |(cause_q & cause_en_q);

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // The pin is open drain: low is driven, high is left to the pull-up.
  assign RST_PIN_O      = 1'b0;
  assign RST_PIN_OE_N_O = ~pulse_active; // [RULE_06]
  assign WDOG_RESET_O   = pulse_active; // [RULE_02]
  assign ILLOP_RESET_O  = illop_q;
  assign STOP_MODE_O    = stop_q;

endmodule // cop_watchdog

// *** design/cop_pkg.sv ***
// Constants, register map and carrier types of the watchdog unit.
// Assumes a word-addressed Avalon-MM slave port and a slow oscillator pin.
package cop_pkg;

  // ------------------------------------------------------------------
  // Register map (word indices on the bus)
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  localparam logic [15:0] SERVICE_IDX = 16'hffff;
  localparam logic [15:0] OPTIONS_IDX = 16'hfff0;
  localparam logic [15:0] CAUSE_IDX   = 16'hfff1;
  localparam logic [15:0] CLEAR_IDX   = 16'hfff2;
  localparam logic [15:0] ENABLE_IDX  = 16'hfff3;
  localparam logic [15:0] COUNT_IDX   = 16'hfff4;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int unsigned OPT_DIS_BIT    = 0;
  localparam int unsigned OPT_RATE_BIT   = 1;
  localparam int unsigned OPT_STOPDIS_BIT = 2;
  localparam logic [2:0]  OPTIONS_RST    = 3'h0;
  localparam int unsigned CAUSE_W        = 2;
  localparam int unsigned CAUSE_WDOG_BIT = 0;
  localparam int unsigned CAUSE_ILL_BIT  = 1;
  localparam logic [1:0]  CAUSE_RST      = 2'h0;
  localparam int unsigned CNT_WAIT_BIT   = 8;
  localparam int unsigned CNT_STOP_BIT   = 9;
  localparam int unsigned CNT_RUN_BIT    = 10;

  // ------------------------------------------------------------------
  // Counter geometry and timing, in oscillator cycles
  // ------------------------------------------------------------------
  localparam int unsigned PRESC_W      = 12;
  localparam int unsigned WDOG_W       = 6;
  localparam int unsigned SVC_CLR_LO   = 4;
  localparam int unsigned ELAPSED_W    = PRESC_W + WDOG_W;
  localparam logic [17:0] TIMEOUT_LONG  = 18'h3ffff - 18'h0000f - 18'h00001 + 18'h00001;
  localparam logic [17:0] TIMEOUT_SHORT = 18'h02000 - 18'h00010;
  localparam int unsigned RST_PULSE_TICKS = 32;
  localparam int unsigned POR_TICKS       = 4096;

  typedef struct packed {
    logic stop_dis;
    logic rate;
    logic dis;
  } options_s;

  typedef struct packed {
    logic on_irq;
    logic on_rst;
  } vtst_s;

endpackage

// *** design/cop_prescaler.sv ***
// Free-running prescaler counter stepped by oscillator ticks.
// Assumes tick_i is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module cop_prescaler #(
  parameter int unsigned WIDTH  = 12,
  parameter int unsigned CLR_LO = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             tick_i,
  input  wire logic             clr_all_i,
  input  wire logic             clr_hi_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  carry_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] hi_mask;

  assign hi_mask = {{(WIDTH-CLR_LO){1'b0}}, {CLR_LO{1'b1}}};
  assign carry_o = tick_i & (&count_q) & ~clr_all_i & ~clr_hi_i;
  assign count_o = count_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (clr_all_i) begin
      count_q <= '0;
    end else if (clr_hi_i) begin
      count_q <= count_q & hi_mask;
    end else if (tick_i) begin
      count_q <= count_q + 1'b1;
    end
  end
endmodule // cop_prescaler

// *** design/cop_pulse_stretch.sv ***
// Holds a reset request for a fixed number of oscillator ticks.
// Assumes start_i and tick_i are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module cop_pulse_stretch #(
  parameter int unsigned TICKS = 32
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic tick_i,
  output logic      active_o
);
  localparam int unsigned CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LOAD = CW'(TICKS);

  logic [CW-1:0] left_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      left_q <= '0;
    end else if (start_i) begin
      left_q <= LOAD;
    end else if (tick_i && left_q != '0) begin
      left_q <= left_q - 1'b1;
    end
  end

  assign active_o = (left_q != '0);
endmodule // cop_pulse_stretch

// *** bench/cop_watchdog_assertions.sv ***
// Concurrent checks on the watchdog unit's top-level ports.
// Assumes the single system clock and its synchronous active-low reset.
`timescale 1ns/1ps
module cop_watchdog_checker (
  input wire logic                        CLK_SYS_I,
  input wire logic                        RST_N_I,
  input wire logic [cop_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
  input wire logic                        AVS_READ_I,
  input wire logic                        AVS_WRITE_I,
  input wire logic [cop_pkg::DATA_W-1:0]  AVS_READDATA_O,
  input wire logic                        AVS_WAITREQUEST_O,
  input wire logic [7:0]                  VECTOR_LO_I,
  input wire logic                        STOP_EXEC_I,
  input wire logic                        STOP_EXIT_I,
  input wire logic                        RST_PIN_O,
  input wire logic                        RST_PIN_OE_N_O,
  input wire logic                        WDOG_RESET_O,
  input wire logic                        ILLOP_RESET_O,
  input wire logic                        STOP_MODE_O,
  input wire logic                        CAUSE_IRQ_O
);
  import cop_pkg::*;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wait_one_a: assert property ($rose(AVS_READ_I | AVS_WRITE_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("bus answer late");
  idle_ready_a: assert property (!(AVS_READ_I | AVS_WRITE_I) |->
    !AVS_WAITREQUEST_O) else $error("wait state while idle");
  vector_read_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
    AVS_ADDRESS_I == SERVICE_IDX |-> AVS_READDATA_O == {24'h0, VECTOR_LO_I})
    else $error("service read not vector byte");
  pin_pair_a: assert property (RST_PIN_OE_N_O == !WDOG_RESET_O)
    else $error("pin drive differs from reset pulse");
  pin_low_a: assert property (RST_PIN_O == 1'b0)
    else $error("reset pin driven high");
  pulse_hold_a: assert property ($rose(WDOG_RESET_O) |-> WDOG_RESET_O[*8])
    else $error("reset pulse too short");
  illop_pulse_a: assert property (ILLOP_RESET_O |-> $past(STOP_EXEC_I) &&
    !STOP_MODE_O ##1 !ILLOP_RESET_O) else $error("illegal stop pulse wrong");
  stop_entry_a: assert property ($rose(STOP_MODE_O) |-> $past(STOP_EXEC_I) &&
    !ILLOP_RESET_O) else $error("stop entered without cause");
  stop_exit_a: assert property (STOP_MODE_O && STOP_EXIT_I |->
    ##[1:2] !STOP_MODE_O) else $error("stop not left");
  reset_quiet_a: assert property ($rose(RST_N_I) |-> RST_PIN_OE_N_O &&
    !STOP_MODE_O && !CAUSE_IRQ_O) else $error("outputs active after reset");
endmodule // cop_watchdog_checker

bind cop_watchdog cop_watchdog_checker i_cop_watchdog_checker (.CLK_SYS_I, .RST_N_I,
  .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
  .VECTOR_LO_I, .STOP_EXEC_I, .STOP_EXIT_I, .RST_PIN_O, .RST_PIN_OE_N_O,
  .WDOG_RESET_O, .ILLOP_RESET_O, .STOP_MODE_O, .CAUSE_IRQ_O);

// *** bench/cop_cpu_model.sv ***
// Processor bus master that issues register and service accesses.
// Assumes the slave raises waitrequest combinationally from the request.
`timescale 1ns/1ps
module cop_cpu_model (
  input  wire logic                       clk_i,
  input  wire logic                       waitreq_i,
  input  wire logic [cop_pkg::DATA_W-1:0] rdata_i,
  output logic      [cop_pkg::ADDR_W-1:0] addr_o,
  output logic                            rd_o,
  output logic                            wr_o,
  output logic      [cop_pkg::DATA_W-1:0] wdata_o,
  output logic      [3:0]                 be_o
);
  import cop_pkg::*;
  initial begin
    addr_o = 16'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
    be_o = 4'hf;
  end
  // Released address and data lines show inverted values so that nothing relies on stale data.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    addr_o <= a;
    wdata_o <= d;
    rd_o <= !w;
    wr_o <= w;
    @(posedge clk_i);
    while (waitreq_i !== 1'b0) @(posedge clk_i);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // cop_cpu_model

// *** bench/cop_watchdog_test.sv ***
// Self-checking bench for the watchdog unit.
// Assumes the oscillator pin runs at 20 MHz against a 100 MHz system clock.
`timescale 1ns/1ps
module cop_watchdog_test;
  import cop_pkg::*;
  logic        clk, rst_n, osc, rd_s, wr_s, wreq, vfetch, stop_go, stop_out, int_rst;
  logic        wait_m, mon_m, brk_m, pin, pin_oe_n, wdog_rst, illop, stop_m, irq;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  be;
  logic [7:0]  vec;
  vtst_s       vtst;
  int          error_cnt, cmp_count, ticks, cyc, t0, n;
  logic [4:0]  mode [6] = '{5'h10, 5'h0a, 5'h09, 5'h05, 5'h06, 5'h00};
  logic        en_exp [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  cop_watchdog i_cop_watchdog (.CLK_SYS_I(clk), .RST_N_I(rst_n), .INTERNAL_OSC_CLOCK_I(osc),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .VECTOR_LO_I(vec), .INT_RST_I(int_rst),
    .VECTOR_FETCH_I(vfetch), .STOP_EXEC_I(stop_go), .STOP_EXIT_I(stop_out),
    .WAIT_MODE_I(wait_m), .MONITOR_MODE_I(mon_m), .BREAK_STATE_I(brk_m),
    .VTST_I(vtst), .RST_PIN_O(pin), .RST_PIN_OE_N_O(pin_oe_n),
    .WDOG_RESET_O(wdog_rst), .ILLOP_RESET_O(illop), .STOP_MODE_O(stop_m),
    .CAUSE_IRQ_O(irq));
  cop_cpu_model i_cop_cpu_model (.clk_i(clk), .waitreq_i(wreq), .rdata_i(rdat),
    .addr_o(adr), .rd_o(rd_s), .wr_o(wr_s), .wdata_o(wdat), .be_o(be));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    forever #25 osc = ~osc;
  end
  always @(posedge osc) ticks++;
  // A hang is cut short well after the longest expected wait.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 95000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_cop_cpu_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a);
    i_cop_cpu_model.xfer(1'b0, a, 32'h0, q);
  endtask
  task print_verdict;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, vfetch, stop_go, stop_out, wait_m, mon_m, brk_m, int_rst} = 8'h0;
    vtst = 2'h0;
    vec = 8'h5a;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr(SERVICE_IDX, 32'h0);
    rd(OPTIONS_IDX); chk(q, 32'h0);
    rd(SERVICE_IDX); chk(q, {24'h0, vec});
    rd(16'h1234); chk(q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OPTIONS_IDX, {31'h0, mode[i][4]});
      mon_m <= mode[i][3];
      brk_m <= mode[i][2];
      vtst <= mode[i][1:0];
      repeat (4) @(posedge clk);
      rd(COUNT_IDX); chk(32'(q[CNT_RUN_BIT]), 32'(en_exp[i]));
    end
    wait_m <= 1'b1;
    rd(COUNT_IDX); chk(32'(q[10:8]), 32'h5);
    stop_go <= 1'b1;
    @(posedge clk);
    stop_go <= 1'b0;
    @(posedge clk);
    @(posedge clk); chk(32'(stop_m), 32'h1);
    rd(COUNT_IDX); chk(32'(q[CNT_STOP_BIT]), 32'h1);
    stop_out <= 1'b1;
    @(posedge clk);
    stop_out <= 1'b0;
    @(posedge clk);
    @(posedge clk); chk(32'(stop_m), 32'h0);
    wr(OPTIONS_IDX, 32'h4);
    stop_go <= 1'b1;
    @(posedge clk);
    stop_go <= 1'b0;
    @(posedge clk); chk(32'({illop, stop_m}), 32'h2);
    rd(CAUSE_IDX); chk(q, 32'h2);
    wr(CLEAR_IDX, 32'h3);
    rd(CAUSE_IDX); chk(q, 32'h0);
    wr(ENABLE_IDX, 32'h1);
    wr(OPTIONS_IDX, 32'h2);
    // The power-on clear must have restarted the prescaler, or the
    // counter would already have stepped here.
    wait (ticks > 4300);
    @(posedge clk);
    rd(COUNT_IDX); chk(32'(q[WDOG_W-1:0]), 32'h0);
    vfetch <= 1'b1;
    @(posedge clk);
    vfetch <= 1'b0;
    t0 = ticks;
    wait (ticks > t0 + 4000);
    @(posedge clk);
    rd(COUNT_IDX); chk(32'(q[WDOG_W-1:0]), 32'h0);
    wait (ticks > t0 + 4150);
    @(posedge clk);
    rd(COUNT_IDX); chk(32'(q[WDOG_W-1:0]), 32'h1);
    wr(SERVICE_IDX, 32'ha5);
    rd(COUNT_IDX); chk(32'(q[WDOG_W-1:0]), 32'h0);
    int_rst <= 1'b1;
    @(posedge clk);
    int_rst <= 1'b0;
    t0 = ticks;
    wait (wdog_rst === 1'b1);
    n = ticks - t0;
    t0 = ticks;
    chk(32'(n >= int'(TIMEOUT_SHORT) - 2 && n <= int'(TIMEOUT_SHORT) + 2), 32'h1);
    @(posedge clk); chk(32'({pin_oe_n, irq}), 32'h1);
    rd(CAUSE_IDX); chk(q, 32'h1);
    wait (wdog_rst === 1'b0);
    n = ticks - t0;
    chk(32'(n >= RST_PULSE_TICKS - 1 && n <= RST_PULSE_TICKS + 1), 32'h1);
    wr(ENABLE_IDX, 32'h0); chk(32'(irq), 32'h0);
    wr(CLEAR_IDX, 32'h1);
    rd(CAUSE_IDX); chk(q, 32'h0);
    print_verdict();
  end
endmodule // cop_watchdog_test
